// ===== include/mioc_pkg.sv
// constants and types shared by the motor i/o command logic
// Behaviour
// - forward command turns shaft forward, ramping with acceleration time
// - backward command alone turns shaft in reverse
// - dropping a run command decelerates to stop with deceleration time
// - both run commands together stop the motor instantly
// - a setting swaps physical direction for each run command
// - two select inputs pick one of four operation data sets
// - fault clear clears active alarm; host removes cause first
// - brake release input keeps brake released while no alarm is active
// - brake release input blocks run commands and motor drive
// - brake release while running removes drive, motor coasts
// - external fault input low raises alarm, stops motor, shows code
// - tachometer gives twelve pulses per shaft revolution
// - fault output on when healthy, off while alarm active
// - thermal output follows protector open and reclose
// - thermal output valid only while main power applied
// - warning output follows warning condition, no clear needed
// - six assignable inputs, two assignable outputs, selectable functions
// - panel brake release honoured only at standstill
// - brake release input disables panel brake operation
// - mode key held five seconds toggles edit lock with indication
// - edit lock rejects operation data and parameter changes
// - attempted change under lock shows lock indication about one second
// - alarm cleared on rising edge of fault clear
// - fault clear ignored while a run command is asserted
package mioc_pkg;
  localparam int unsigned MIOC_CLK_HZ = 250_000_000;
  localparam int unsigned MIOC_LOCK_HOLD_MS = 5000;
  localparam int unsigned MIOC_LOCK_SHOW_MS = 1000;
  localparam int unsigned MIOC_LOCK_HOLD_CYC = MIOC_CLK_HZ / 1000 * MIOC_LOCK_HOLD_MS;
  localparam int unsigned MIOC_LOCK_SHOW_CYC = MIOC_CLK_HZ / 1000 * MIOC_LOCK_SHOW_MS;
  localparam int unsigned MIOC_TMR_W = 32;
  localparam int unsigned MIOC_NUM_IN = 6;
  localparam int unsigned MIOC_NUM_OUT = 2;
  localparam int unsigned MIOC_PULSES_PER_REV = 12;
  localparam logic [11:0] MIOC_ADDR_CTRL = 12'h000;
  localparam logic [11:0] MIOC_ADDR_MAP_IN = 12'h004;
  localparam logic [11:0] MIOC_ADDR_MAP_OUT = 12'h008;
  localparam logic [11:0] MIOC_ADDR_STATUS = 12'h00c;
  localparam logic [11:0] MIOC_ADDR_EDIT = 12'h010;
  localparam logic [11:0] MIOC_ADDR_DATA0 = 12'h020;
  localparam int unsigned MIOC_DATA_W = 32;
  localparam int unsigned MIOC_CTRL_DIR_BIT = 0;
  localparam int unsigned MIOC_CTRL_ACTIVE_BIT = 1;
  localparam logic [17:0] MIOC_MAP_IN_RESET = {3'h5, 3'h4, 3'h3, 3'h2, 3'h1, 3'h0};
  localparam logic [5:0] MIOC_MAP_OUT_RESET = {3'h1, 3'h0};
  localparam logic [7:0] MIOC_ALARM_NONE = 8'h00;
  localparam logic [7:0] MIOC_ALARM_EXT_STOP = 8'h6e;
  localparam logic [MIOC_DATA_W-1:0] MIOC_ZERO = 32'h0000_0000;
  // input functions
  typedef enum logic [2:0]
  {
    MIOC_FN_FWD = 3'h0,
    MIOC_FN_BWD = 3'h1,
    MIOC_FN_SEL0 = 3'h2,
    MIOC_FN_SEL1 = 3'h3,
    MIOC_FN_CLR = 3'h4,
    MIOC_FN_FREE = 3'h5,
    MIOC_FN_EXT = 3'h6,
    MIOC_FN_NONE = 3'h7
  } mioc_in_fn_t;
  // output functions
  typedef enum logic [2:0]
  {
    MIOC_OF_TACH = 3'h0,
    MIOC_OF_FAULT = 3'h1,
    MIOC_OF_THERM = 3'h2,
    MIOC_OF_WARN = 3'h3
  } mioc_out_fn_t;
  // drive state, gray along idle-accel-run-decel
  typedef enum logic [2:0]
  {
    MIOC_ST_IDLE = 3'b000,
    MIOC_ST_ACCEL = 3'b001,
    MIOC_ST_RUN = 3'b011,
    MIOC_ST_DECEL = 3'b010,
    MIOC_ST_COAST = 3'b110
  } mioc_state_t;
endpackage

// ===== rtl/mioc_top.sv
// motor i/o command logic with apb configuration
`timescale 1ns/10ps
module mioc_top
  import mioc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [MIOC_NUM_IN-1:0] input_terminal,
  input wire logic mode_key,
  input wire logic panel_brake_req,
  input wire logic thermal_open,
  input wire logic ac_power_ok,
  input wire logic warning_cond,
  input wire logic motor_stopped,
  input wire logic shaft_tick,
  input wire logic ramp_done,
  output logic [MIOC_NUM_OUT-1:0] output_terminal,
  output logic motor_enable,
  output logic motor_forward,
  output logic motor_ramp,
  output logic motor_instant_stop,
  output logic brake_release,
  output logic [1:0] op_data_index,
  output logic [MIOC_DATA_W-1:0] op_data_value,
  output logic [7:0] alarm_code,
  output logic lock_indication,
  output logic unlock_indication
);
  // decode one input slot's function from the map register
  function automatic logic [2:0] mioc_slot_fn(input logic [17:0] map, input int unsigned idx);
    mioc_slot_fn = map[idx*3 +: 3];
  endfunction

  // synchroniser: two flip-flops per terminal, mode key, panel brake, thermal and ac power level
  logic [9:0] sync1_reg;
  logic [9:0] sync2_reg;
  logic [9:0] raw_in;
  assign raw_in = {input_terminal, mode_key, panel_brake_req, thermal_open, ac_power_ok};
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end
    else
    begin
      sync1_reg <= raw_in;
      sync2_reg <= sync1_reg;
    end
  end
  logic [MIOC_NUM_IN-1:0] term_s;
  logic key_s;
  logic pbrake_s;
  logic therm_s;
  logic acok_s;
  assign term_s = sync2_reg[9:4];
  assign key_s = sync2_reg[3];
  assign pbrake_s = sync2_reg[2];
  assign therm_s = sync2_reg[1];
  assign acok_s = sync2_reg[0];

  // register file state
  logic [1:0] ctrl_reg, ctrl_next;
  logic [17:0] map_in_reg, map_in_next;
  logic [5:0] map_out_reg, map_out_next;
  logic [MIOC_DATA_W-1:0] data_reg [4];
  logic [MIOC_DATA_W-1:0] data_next [4];
  logic [31:0] prdata_next;
  logic pready_next, pslverr_next;
  logic edit_reject;
  logic lock_wr;

  // function routing from the six terminals
  logic fwd_in, bwd_in, sel0_in, sel1_in, clr_in, free_in, ext_ok;
  logic ext_mapped;
  always_comb
  begin
    fwd_in = 1'b0;
    bwd_in = 1'b0;
    sel0_in = 1'b0;
    sel1_in = 1'b0;
    clr_in = 1'b0;
    free_in = 1'b0;
    ext_ok = 1'b1;
    ext_mapped = 1'b0;
    for (int unsigned i = 0; i < MIOC_NUM_IN; i++)
    begin
      unique case (mioc_in_fn_t'(mioc_slot_fn(map_in_reg, i)))
        MIOC_FN_FWD: fwd_in = fwd_in | term_s[i];
        MIOC_FN_BWD: bwd_in = bwd_in | term_s[i];
        MIOC_FN_SEL0: sel0_in = sel0_in | term_s[i];
        MIOC_FN_SEL1: sel1_in = sel1_in | term_s[i];
        MIOC_FN_CLR: clr_in = clr_in | term_s[i];
        MIOC_FN_FREE: free_in = free_in | term_s[i];
        MIOC_FN_EXT:
        begin
          ext_mapped = 1'b1;
          ext_ok = ext_ok & term_s[i];
        end
        MIOC_FN_NONE: ;
      endcase
    end
  end

  // alarm and drive state
  mioc_state_t st_reg, st_next;
  logic alarm_reg, alarm_next;
  logic [7:0] code_reg, code_next;
  logic clr_d_reg;
  logic brake_reg, brake_next;
  logic fwd_o_next, ramp_next, inst_next, en_next;
  logic run_req;
  logic clr_edge;
  assign run_req = (fwd_in ^ bwd_in) && !free_in && !alarm_reg;
  assign clr_edge = clr_in && !clr_d_reg;

  always_comb
  begin
    st_next = st_reg;
    alarm_next = alarm_reg;
    code_next = code_reg;
    if (ext_mapped && !ext_ok)
    begin
      alarm_next = 1'b1;
      code_next = MIOC_ALARM_EXT_STOP;
    end
    // clear only with both run commands off
    else if (alarm_reg && clr_edge && !fwd_in && !bwd_in)
    begin
      alarm_next = 1'b0;
      code_next = MIOC_ALARM_NONE;
    end
    unique case (st_reg)
      MIOC_ST_IDLE: if (run_req) st_next = MIOC_ST_ACCEL;
      MIOC_ST_ACCEL: if (!run_req) st_next = MIOC_ST_DECEL;
        else if (ramp_done) st_next = MIOC_ST_RUN;
      MIOC_ST_RUN: if (!run_req) st_next = MIOC_ST_DECEL;
      // a finished deceleration ramp or motor standstill ends the stop
      MIOC_ST_DECEL: if (run_req) st_next = MIOC_ST_ACCEL;
        else if (ramp_done || motor_stopped) st_next = MIOC_ST_IDLE;
      MIOC_ST_COAST: if (motor_stopped) st_next = MIOC_ST_IDLE;
      default: st_next = MIOC_ST_IDLE;
    endcase
    if (free_in && st_reg != MIOC_ST_IDLE)
      st_next = MIOC_ST_COAST;
    if ((fwd_in && bwd_in) || alarm_next)
      st_next = MIOC_ST_IDLE;
    // drive only in ramp or run states
    en_next = (st_next == MIOC_ST_ACCEL) || (st_next == MIOC_ST_RUN)
      || (st_next == MIOC_ST_DECEL);
    // ramp flag covers acceleration and deceleration
    ramp_next = (st_next == MIOC_ST_ACCEL) || (st_next == MIOC_ST_DECEL);
    inst_next = fwd_in && bwd_in;
    fwd_o_next = motor_forward;
    if (run_req)
      fwd_o_next = fwd_in ^ ctrl_reg[MIOC_CTRL_DIR_BIT];
    if (free_in)
      brake_next = !alarm_next;
    else
      brake_next = pbrake_s && motor_stopped && st_reg == MIOC_ST_IDLE && !alarm_next;
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      st_reg <= MIOC_ST_IDLE;
      alarm_reg <= 1'b0;
      code_reg <= MIOC_ALARM_NONE;
      clr_d_reg <= 1'b0;
      brake_reg <= 1'b0;
      motor_enable <= 1'b0;
      motor_forward <= 1'b1;
      motor_ramp <= 1'b0;
      motor_instant_stop <= 1'b0;
      op_data_index <= 2'h0;
    end
    else
    begin
      st_reg <= st_next;
      alarm_reg <= alarm_next;
      code_reg <= code_next;
      clr_d_reg <= clr_in;
      brake_reg <= brake_next;
      motor_enable <= en_next;
      motor_forward <= fwd_o_next;
      motor_ramp <= ramp_next;
      motor_instant_stop <= inst_next;
      op_data_index <= {sel1_in, sel0_in};
    end
  end
  assign brake_release = brake_reg;
  assign alarm_code = code_reg;

  // output terminal functions
  logic [MIOC_NUM_OUT-1:0] out_next;
  always_comb
  begin
    out_next = '0;
    for (int unsigned j = 0; j < MIOC_NUM_OUT; j++)
    begin
      unique case (mioc_out_fn_t'(map_out_reg[j*3 +: 3]))
        MIOC_OF_FAULT: out_next[j] = !alarm_next;
        MIOC_OF_THERM: out_next[j] = therm_s && acok_s;
        MIOC_OF_WARN: out_next[j] = warning_cond;
        // tach follows shaft ticks
        // the motor side gives twelve ticks a revolution, so one pulse per tick keeps the ratio
        MIOC_OF_TACH: out_next[j] = shaft_tick;
        default: out_next[j] = 1'b0;
      endcase
    end
  end
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      output_terminal <= '0;
    else
      output_terminal <= out_next;
  end

  // edit lock: hold timer and indication timer
  logic lock_reg, lock_next;
  logic [MIOC_TMR_W-1:0] hold_reg, hold_next;
  logic [MIOC_TMR_W-1:0] show_reg, show_next;
  logic held_reg, held_next;
  logic lki_next, uli_next;
  always_comb
  begin
    lock_next = lock_reg;
    held_next = held_reg;
    hold_next = hold_reg;
    show_next = show_reg;
    lki_next = lock_indication;
    uli_next = unlock_indication;
    // five second hold toggles lock once per press
    if (!key_s)
    begin
      hold_next = '0;
      held_next = 1'b0;
    end
    else if (!held_reg)
    begin
      if (hold_reg == MIOC_TMR_W'(MIOC_LOCK_HOLD_CYC - 1))
      begin
        held_next = 1'b1;
        lock_next = !lock_reg;
        lki_next = !lock_reg;
        uli_next = lock_reg;
        show_next = MIOC_TMR_W'(MIOC_LOCK_SHOW_CYC);
      end
      else
        hold_next = hold_reg + 1'b1;
    end
    // software may set or drop the lock too; it wins over the key in a tie
    if (lock_wr)
      lock_next = pwdata[0];
    // one second lock indication on rejected edit
    if (edit_reject)
    begin
      lki_next = 1'b1;
      uli_next = 1'b0;
      show_next = MIOC_TMR_W'(MIOC_LOCK_SHOW_CYC);
    end
    else if (show_reg != '0)
    begin
      show_next = show_reg - 1'b1;
      if (show_reg == MIOC_TMR_W'(1))
      begin
        lki_next = 1'b0;
        uli_next = 1'b0;
      end
    end
  end
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      lock_reg <= 1'b0;
      held_reg <= 1'b0;
      hold_reg <= '0;
      show_reg <= '0;
      lock_indication <= 1'b0;
      unlock_indication <= 1'b0;
    end
    else
    begin
      lock_reg <= lock_next;
      held_reg <= held_next;
      hold_reg <= hold_next;
      show_reg <= show_next;
      lock_indication <= lki_next;
      unlock_indication <= uli_next;
    end
  end

  // apb slave: one wait state in the access phase, errors on unmapped address
  logic acc;
  logic wr_data;
  assign acc = psel && penable && !pready;
  assign wr_data = (paddr == MIOC_ADDR_CTRL) || (paddr == MIOC_ADDR_MAP_IN)
    || (paddr == MIOC_ADDR_MAP_OUT) || (paddr[11:4] == MIOC_ADDR_DATA0[11:4]);
  // lock rejects data and parameter writes
  assign edit_reject = acc && pwrite && lock_reg && wr_data;
  // the lock word itself stays writable, else software could never unlock a locked part
  assign lock_wr = acc && pwrite && (paddr == MIOC_ADDR_EDIT);
  always_comb
  begin
    ctrl_next = ctrl_reg;
    map_in_next = map_in_reg;
    map_out_next = map_out_reg;
    for (int k = 0; k < 4; k++)
      data_next[k] = data_reg[k];
    prdata_next = MIOC_ZERO;
    pready_next = acc;
    pslverr_next = 1'b0;
    if (acc)
    begin
      if (paddr == MIOC_ADDR_CTRL)
      begin
        prdata_next = {30'h0, ctrl_reg};
        if (pwrite && !lock_reg) ctrl_next = pwdata[1:0];
      end
      else if (paddr == MIOC_ADDR_MAP_IN)
      begin
        prdata_next = {14'h0, map_in_reg};
        if (pwrite && !lock_reg) map_in_next = pwdata[17:0];
      end
      else if (paddr == MIOC_ADDR_MAP_OUT)
      begin
        prdata_next = {26'h0, map_out_reg};
        if (pwrite && !lock_reg) map_out_next = pwdata[5:0];
      end
      else if (paddr == MIOC_ADDR_STATUS)
        prdata_next = {16'h0, code_reg, 2'h0, lock_reg, brake_reg, alarm_reg, st_reg};
      else if (paddr == MIOC_ADDR_EDIT)
        prdata_next = {31'h0, lock_reg};
      else if (paddr[11:4] == MIOC_ADDR_DATA0[11:4] && paddr[1:0] == 2'h0)
      begin
        prdata_next = data_reg[paddr[3:2]];
        if (pwrite && !lock_reg) data_next[paddr[3:2]] = pwdata;
      end
      else
        pslverr_next = 1'b1;
    end
  end
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      ctrl_reg <= 2'h0;
      map_in_reg <= MIOC_MAP_IN_RESET;
      map_out_reg <= MIOC_MAP_OUT_RESET;
      for (int k = 0; k < 4; k++)
        data_reg[k] <= MIOC_ZERO;
      prdata <= MIOC_ZERO;
      pready <= 1'b0;
      pslverr <= 1'b0;
      op_data_value <= MIOC_ZERO;
    end
    else
    begin
      ctrl_reg <= ctrl_next;
      map_in_reg <= map_in_next;
      map_out_reg <= map_out_next;
      for (int k = 0; k < 4; k++)
        data_reg[k] <= data_next[k];
      prdata <= prdata_next;
      pready <= pready_next;
      pslverr <= pslverr_next;
      op_data_value <= data_reg[op_data_index];
    end
  end

  // assertions
  chk_both_instant: assert property (@(posedge clk_sys) disable iff (!resetn)
    (fwd_in && bwd_in) |=> !motor_enable && motor_instant_stop)
    else $error("both run commands did not stop motor");
  chk_free_no_drive: assert property (@(posedge clk_sys) disable iff (!resetn)
    free_in |=> !motor_enable)
    else $error("motor driven while brake release input on");
  // the terminal register was loaded through the map of the cycle before
  chk_fault_out_safe: assert property (@(posedge clk_sys) disable iff (!resetn)
    (alarm_reg && $past(map_out_reg[5:3]) == MIOC_OF_FAULT) |-> !output_terminal[1])
    else $error("fault output on during alarm");
  chk_clr_blocked_run: assert property (@(posedge clk_sys) disable iff (!resetn)
    (alarm_reg && (fwd_in || bwd_in) && ext_ok) |=> alarm_reg)
    else $error("alarm cleared while run command on");
  chk_ext_alarm_set: assert property (@(posedge clk_sys) disable iff (!resetn)
    (ext_mapped && !ext_ok) |=> alarm_reg && alarm_code == MIOC_ALARM_EXT_STOP)
    else $error("external fault did not raise alarm");
  chk_lock_write_block: assert property (@(posedge clk_sys) disable iff (!resetn)
    (edit_reject && paddr == MIOC_ADDR_CTRL) |=> $stable(ctrl_reg))
    else $error("write accepted under edit lock");
  chk_reject_shows_lock: assert property (@(posedge clk_sys) disable iff (!resetn)
    edit_reject |=> lock_indication [*8])
    else $error("lock indication not shown after rejected edit");
  chk_therm_needs_ac: assert property (@(posedge clk_sys) disable iff (!resetn)
    (!acok_s && map_out_reg[2:0] == MIOC_OF_THERM) |=> !output_terminal[0])
    else $error("thermal output on without ac power");
endmodule

// ===== verif/mioc_motor_model.sv
// stand-in for the motor on the far side of the drive outputs
`timescale 1ns/10ps
module mioc_motor_model
#(
  parameter int TICK_CYC = 8,
  parameter int RAMP_CYC = 16,
  parameter int STOP_CYC = 20
)
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic motor_enable,
  input wire logic motor_ramp,
  output logic motor_stopped,
  output logic shaft_tick,
  output logic ramp_done
);
  int tick_cnt;
  int ramp_cnt;
  int idle_cnt;
  logic ramp_q;
  // ----------------------------------------
  // shaft, ramp and standstill behaviour
  // ----------------------------------------
  // the shaft keeps turning for a while after drive goes away, so standstill lags
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      tick_cnt <= 0;
      ramp_cnt <= 0;
      idle_cnt <= STOP_CYC;
      ramp_q <= 1'b0;
      shaft_tick <= 1'b0;
      ramp_done <= 1'b0;
      motor_stopped <= 1'b1;
    end
    else
    begin
      ramp_q <= motor_ramp;
      // a ramp ends some time after it starts, whichever way it goes
      ramp_cnt <= (!motor_enable || motor_ramp != ramp_q) ? 0 : ramp_cnt + 1;
      ramp_done <= motor_enable && (ramp_cnt == RAMP_CYC - 1);
      // twelve ticks make one revolution at the output shaft
      tick_cnt <= (!motor_enable || tick_cnt == TICK_CYC - 1) ? 0 : tick_cnt + 1;
      shaft_tick <= motor_enable && (tick_cnt == TICK_CYC - 1);
      idle_cnt <= motor_enable ? 0 : ((idle_cnt < STOP_CYC) ? idle_cnt + 1 : idle_cnt);
      motor_stopped <= !motor_enable && (idle_cnt >= STOP_CYC);
    end
  end
endmodule

// ===== verif/mioc_tb_top.sv
// self-checking bench for the motor i/o command logic
`timescale 1ns/10ps
module mioc_tb_top
  import mioc_pkg::*;
;
  logic clk_sys, resetn, psel, penable, pwrite, pready, pslverr, rd_err, counting;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd_data, op_data_value;
  logic [5:0] input_terminal;
  logic mode_key, panel_brake_req, thermal_open, ac_power_ok, warning_cond;
  logic motor_stopped, shaft_tick, ramp_done, motor_enable, motor_forward, motor_ramp;
  logic motor_instant_stop, brake_release, lock_indication, unlock_indication;
  logic [1:0] output_terminal, op_data_index;
  logic [7:0] alarm_code;
  int err_count, num_checks, cyc, tick_n, pulse_n;
  mioc_top uut (.clk_sys, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .input_terminal, .mode_key, .panel_brake_req, .thermal_open,
    .ac_power_ok, .warning_cond, .motor_stopped, .shaft_tick, .ramp_done, .output_terminal,
    .motor_enable, .motor_forward, .motor_ramp, .motor_instant_stop, .brake_release,
    .op_data_index, .op_data_value, .alarm_code, .lock_indication, .unlock_indication);
  mioc_motor_model motor (.clk_sys, .resetn, .motor_enable, .motor_ramp, .motor_stopped,
    .shaft_tick, .ramp_done);
  // ----------------------------------------
  // clock, watchdog and tach counting
  // ----------------------------------------
  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  // a hung handshake must still end the run with a verdict
  always @(posedge clk_sys)
  begin
    cyc++;
    if (counting && shaft_tick === 1'b1) tick_n++;
    if (counting && output_terminal[0] === 1'b1) pulse_n++;
    if (cyc == 30000)
    begin
      err_count++;
      final_report();
    end
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task final_report;
    if (err_count == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task check(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  // one apb transfer; the answer is awaited, never assumed
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    // only the bench watchdog may end this wait
    do
    begin
      @(posedge clk_sys);
    end
    while (pready !== 1'b1);
    rd_data = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // terminals pass a synchroniser, so give them time to land
  task term(input logic [5:0] v);
    @(posedge clk_sys);
    input_terminal <= v;
    repeat (8) @(posedge clk_sys);
  endtask
  task wait_off;
    int n;
    n = 0;
    while (motor_enable !== 1'b0 && n < 300)
    begin
      @(posedge clk_sys);
      n++;
    end
    repeat (30) @(posedge clk_sys);
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    {psel, penable, pwrite, mode_key, panel_brake_req, thermal_open, warning_cond} = 7'h00;
    {counting, err_count, num_checks, cyc, tick_n, pulse_n} = '0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    input_terminal = 6'h00;
    ac_power_ok = 1'b1;
    resetn = 1'b0;
    repeat (5) @(posedge clk_sys);
    check("forward_rst", 32'h1, 32'(motor_forward));
    resetn <= 1'b1;
    apb(0, MIOC_ADDR_MAP_IN, MIOC_ZERO);
    check("map_in", 32'(MIOC_MAP_IN_RESET), rd_data);
    apb(0, MIOC_ADDR_MAP_OUT, MIOC_ZERO);
    check("map_out", 32'(MIOC_MAP_OUT_RESET), rd_data);
    apb(0, MIOC_ADDR_STATUS, MIOC_ZERO);
    check("status", 32'h0, rd_data);
    check("fault_out", 32'h1, 32'(output_terminal[1]));
    apb(0, 12'h0fc, MIOC_ZERO);
    check("slverr", 32'h1, 32'(rd_err));
    // run forward, then stop by deceleration while tach pulses are counted
    counting <= 1'b1;
    term(6'h01);
    check("enable", 32'h1, 32'(motor_enable));
    check("forward", 32'h1, 32'(motor_forward));
    check("ramp_up", 32'h1, 32'(motor_ramp));
    repeat (200) @(posedge clk_sys);
    check("ramp_end", 32'h0, 32'(motor_ramp));
    term(6'h00);
    check("ramp_down", 32'h1, 32'(motor_ramp));
    wait_off;
    check("enable_off", 32'h0, 32'(motor_enable));
    counting <= 1'b0;
    check("tach_seen", 32'h1, 32'(tick_n != 0));
    check("tach_pulses", 32'(tick_n), 32'(pulse_n));
    term(6'h02);
    check("reverse", 32'h0, 32'(motor_forward));
    term(6'h03);
    check("instant_stop", 32'h1, 32'(motor_instant_stop));
    term(6'h00);
    wait_off;
    apb(1, MIOC_ADDR_CTRL, 32'h0000_0001);
    term(6'h02);
    check("swapped", 32'h1, 32'(motor_forward));
    term(6'h00);
    wait_off;
    apb(1, MIOC_ADDR_CTRL, MIOC_ZERO);
    // brake release on a running motor, then run commands under release
    term(6'h01);
    term(6'h21);
    check("coast", 32'h0, 32'(motor_enable));
    check("brake", 32'h1, 32'(brake_release));
    term(6'h20);
    term(6'h21);
    check("blocked", 32'h0, 32'(motor_enable));
    term(6'h00);
    wait_off;
    // panel brake release only at standstill
    @(posedge clk_sys);
    panel_brake_req <= 1'b1;
    term(6'h00);
    check("panel_brake", 32'h1, 32'(brake_release));
    panel_brake_req <= 1'b0;
    term(6'h01);
    panel_brake_req <= 1'b1;
    term(6'h01);
    check("panel_moving", 32'h0, 32'(brake_release));
    panel_brake_req <= 1'b0;
    term(6'h00);
    wait_off;
    // every operation data select code
    for (int i = 0; i < 4; i++) apb(1, MIOC_ADDR_DATA0 + 12'(4 * i), 32'ha5a5_0000 + 32'(i));
    for (int i = 0; i < 4; i++)
    begin
      term({2'b00, 2'(i), 2'b00});
      check("op_index", 32'(i), 32'(op_data_index));
      check("op_value", 32'ha5a5_0000 + 32'(i), op_data_value);
    end
    // terminal 5 becomes the external fault input, held healthy first
    term(6'h20);
    apb(1, MIOC_ADDR_MAP_IN, 32'({3'h6, 3'h4, 3'h3, 3'h2, 3'h1, 3'h0}));
    term(6'h21);
    term(6'h01);
    check("ext_code", 32'(MIOC_ALARM_EXT_STOP), 32'(alarm_code));
    check("fault_off", 32'h0, 32'(output_terminal[1]));
    wait_off;
    check("ext_stop", 32'h0, 32'(motor_enable));
    term(6'h21);
    term(6'h31);
    check("clr_in_run", 32'(MIOC_ALARM_EXT_STOP), 32'(alarm_code));
    term(6'h20);
    term(6'h30);
    check("cleared", 32'(MIOC_ALARM_NONE), 32'(alarm_code));
    check("fault_on", 32'h1, 32'(output_terminal[1]));
    term(6'h10);
    term(6'h30);
    check("clr_level", 32'(MIOC_ALARM_EXT_STOP), 32'(alarm_code));
    term(6'h20);
    term(6'h30);
    check("clr_edge", 32'(MIOC_ALARM_NONE), 32'(alarm_code));
    term(6'h20);
    apb(1, MIOC_ADDR_MAP_IN, 32'(MIOC_MAP_IN_RESET));
    term(6'h00);
    // outputs remapped to thermal trip and warning
    apb(1, MIOC_ADDR_MAP_OUT, 32'h0000_001a);
    thermal_open <= 1'b1;
    warning_cond <= 1'b1;
    term(6'h00);
    check("therm_on", 32'h1, 32'(output_terminal[0]));
    check("warn_on", 32'h1, 32'(output_terminal[1]));
    ac_power_ok <= 1'b0;
    term(6'h00);
    check("therm_no_ac", 32'h0, 32'(output_terminal[0]));
    ac_power_ok <= 1'b1;
    thermal_open <= 1'b0;
    warning_cond <= 1'b0;
    term(6'h00);
    check("therm_off", 32'h0, 32'(output_terminal[0]));
    check("warn_off", 32'h0, 32'(output_terminal[1]));
    apb(1, MIOC_ADDR_MAP_OUT, 32'(MIOC_MAP_OUT_RESET));
    // edit lock refuses a configuration write, unlocking lets it through again
    apb(1, MIOC_ADDR_EDIT, 32'h0000_0001);
    apb(1, MIOC_ADDR_CTRL, 32'h0000_0001);
    apb(0, MIOC_ADDR_CTRL, MIOC_ZERO);
    check("locked_ctrl", 32'h0, rd_data);
    check("lock_ind", 32'h1, 32'(lock_indication));
    check("unlock_ind", 32'h0, 32'(unlock_indication));
    apb(0, MIOC_ADDR_STATUS, MIOC_ZERO);
    check("lock_bit", 32'h1, 32'(rd_data[5]));
    apb(1, MIOC_ADDR_EDIT, MIOC_ZERO);
    apb(1, MIOC_ADDR_CTRL, 32'h0000_0001);
    apb(0, MIOC_ADDR_CTRL, MIOC_ZERO);
    check("unlocked_ctrl", 32'h1, rd_data);
    final_report();
  end
endmodule
